// [hw/ssd_consts.vh]
// Constants for the serial status and data path block
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH

// Register indices on the plain register port
`define SSD_ADDR_STATUS   4'h0
`define SSD_ADDR_RXDATA   4'h1
`define SSD_ADDR_TXDATA   4'h2
`define SSD_ADDR_SKIP     4'h3
`define SSD_ADDR_CTRL     4'h4
`define SSD_ADDR_VECTOR   4'h5

// Status bit positions
`define SSD_ST_IF0        0
`define SSD_ST_IF1        1
`define SSD_ST_TFS        2
`define SSD_ST_RFS        3
`define SSD_ST_TUE        4
`define SSD_ST_ROE        5
`define SSD_ST_TDE        6
`define SSD_ST_RDF        7

// Control bit positions
`define SSD_CT_WL_LO      0
`define SSD_CT_WL_HI      1
`define SSD_CT_SHIFT_ORDER_SELECT       2
`define SSD_CT_FSL_LO     3
`define SSD_CT_FSL_HI     4
`define SSD_CT_SYN        5
`define SSD_CT_MOD        6
`define SSD_CT_TE         7
`define SSD_CT_RE         8
`define SSD_CT_TIE        9
`define SSD_CT_RIE        10
`define SSD_CT_DIR0       11
`define SSD_CT_DIR1       12
`define SSD_CT_FSINT      13
`define SSD_CT_SLOTS_LO   14
`define SSD_CT_SLOTS_HI   18

// Reset values
`define SSD_CTRL_RESET    19'h00000
`define SSD_STATUS_RESET  8'h40

// Timing counts: two-flop synchroniser depth
`define SSD_SYNC_STAGES   2

`endif

// [hw/ssd_port.v]
// Serial port status flags, holding registers and shift data path
`include "ssd_consts.vh"

//Function
// - Aux pin one sampled at first bit of each slot's word, copied on receive transfer.
// - Input flag one reads only when pin is input and sync mode.
// - Transmit frame-start flag set in first slot, cleared in others.
// - Word-length sync: high at slot start (external) or whole slot (internal).
// - Bit-length sync: high during last bit before slot; falls at first bit.
// - Network: word written in first slot is sent in second slot.
// - Normal mode has one slot; receive frame-start flag reads one, transmit flag clears when the slot ends without sync.
// - Resets clear frame-start flags; enable bits do not touch them.
// - Receive frame-start flag tells if held word came with frame sync.
// - Receive sync qualifier chosen by upper frame-sync length bit.
// - Slot without new data sets underrun and resends previous word.
// - Error flags only pick the exception vector; no interrupt themselves.
// - Underrun cleared by status read then transmit or skip write.
// - Word done while receive word full sets overrun, word dropped.
// - Transmit word is 24-bit write-only, left-justified, auto-forwarded.
// - Overrun cleared by status read then receive read; enable irrelevant.
// - Empty flag set on transfer, skipped slot, reset; cleared on write.
// - Transmit interrupt when empty and enabled; vector follows underrun.
// - Full flag set on transfer, cleared on read; vector follows overrun.
// - Receive shift samples data under sync, order and length selectable.
// - Receive word read-only, left-justified, low unused bits zero.
// - Transmit shift left-justified, MSB or LSB first per order bit.
// - Skip write acts as transmit write but output floats that slot.
// - Status is eight bits read-only, upper bits zero.
// - Input flag zero mirrors flag one using aux pin zero.
module ssd_port #(
    parameter WIDTH = 24
) (
    // Clock and reset
    input  wire             CLOCK,
    input  wire             RST,
    // Software register port
    input  wire [3:0]       ADDR,
    input  wire [23:0]      WDATA,
    input  wire             WR,
    input  wire             RD,
    output reg  [23:0]      RDATA,
    // Serial link pins
    input  wire             BIT_CLK,
    input  wire             FRAME_SYNC,
    input  wire             SERIAL_IN,
    input  wire             AUX_PIN_ZERO,
    input  wire             AUX_PIN_ONE,
    output wire             SERIAL_OUT_PIN,
    output wire             SERIAL_OUT_PIN_OE,
    // Interrupt requests and vector choice
    output wire             TX_IRQ,
    output wire             TX_IRQ_EXC,
    output wire             RX_IRQ,
    output wire             RX_IRQ_EXC
);
    reg  [18:0]      ctrl;
    reg  [1:0]       clk_s, fs_s, din_s, a0_s, a1_s;
    reg              clk_d;
    reg  [WIDTH-1:0] tx_hold;
    reg  [WIDTH-1:0] rx_hold;
    reg              tx_frame_start_flag, rx_frame_start_flag;
    reg              tx_underrun_flag, rx_overrun_flag;
    reg              tx_holding_empty, rx_holding_full;
    reg              input_flag_zero, input_flag_one;
    reg              tue_armed, roe_armed;
    reg              tx_skip_pending, tx_skip_slot, tx_active;
    reg              rx_sync_seen, rx_flag0_smp, rx_flag1_smp, rx_first;
    reg              fs_prev_bit;
    reg  [4:0]       tx_cnt, rx_cnt, slot_idx;
    reg  [4:0]       wl_bits;
    wire             bclk, fsync, din;
    wire             rise, fall;
    wire             slot_start, rx_done;
    wire             tx_sync_ok, rx_sync_ok;
    wire             lsb_first;
    wire [1:0]       word_len;
    wire [WIDTH-1:0] rx_word;
    wire [WIDTH-1:0] rx_full;
    wire [4:0]       rx_shl;
    wire             tx_bit;
    wire             status_rd, rx_rd, tx_wr, skip_wr;
    wire [7:0]       status;

    assign word_len  = ctrl[`SSD_CT_WL_HI:`SSD_CT_WL_LO];
    assign lsb_first = ctrl[`SSD_CT_SHIFT_ORDER_SELECT];
    assign status_rd = RD && (ADDR == `SSD_ADDR_STATUS);
    assign rx_rd     = RD && (ADDR == `SSD_ADDR_RXDATA);
    assign tx_wr     = WR && (ADDR == `SSD_ADDR_TXDATA);
    assign skip_wr   = WR && (ADDR == `SSD_ADDR_SKIP);

    // Two-flop synchronisers on every serial link input pin; only stage 1 is read
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            clk_s <= 2'h0;
            fs_s  <= 2'h0;
            din_s <= 2'h0;
            a0_s  <= 2'h0;
            a1_s  <= 2'h0;
            clk_d <= 1'b0;
        end else begin
            clk_s <= {clk_s[0], BIT_CLK};
            fs_s  <= {fs_s[0], FRAME_SYNC};
            din_s <= {din_s[0], SERIAL_IN};
            a0_s  <= {a0_s[0], AUX_PIN_ZERO};
            a1_s  <= {a1_s[0], AUX_PIN_ONE};
            clk_d <= clk_s[1];
        end
    end

    assign bclk  = clk_s[1];
    assign fsync = fs_s[1];
    assign din   = din_s[1];
    // Drive on rising edge, sample on falling edge of the bit clock
    assign rise  = bclk && !clk_d;
    assign fall  = !bclk && clk_d;

    // Word length in bits minus one
    always @* begin
        case (word_len)
            2'h0:    wl_bits = 5'h07;
            2'h1:    wl_bits = 5'h0b;
            2'h2:    wl_bits = 5'h0f;
            default: wl_bits = 5'h17;
        endcase
    end

    // Bit-length sync (FSL bits differ for tx) is qualified by the last bit before the slot
    assign tx_sync_ok = (ctrl[`SSD_CT_FSL_LO] != ctrl[`SSD_CT_FSL_HI]) ?
                        fs_prev_bit : fsync;
    assign rx_sync_ok = ctrl[`SSD_CT_FSL_HI] ? fs_prev_bit : fsync;
    // A slot begins at the word boundary, or on sync when idle
    assign slot_start = rise && ((tx_cnt == 5'h00 && tx_active) || (!tx_active && tx_sync_ok));
    assign rx_done    = fall && tx_active && (rx_cnt == wl_bits);

    // Completed word with its last bit; MSB-first fills from the bottom and is lifted
    // to the top of the field, LSB-first already arrives left-justified
    assign rx_shl  = 5'h17 - wl_bits;
    assign rx_full = lsb_first ? {din, rx_word[WIDTH-1:1]} :
                     ({rx_word[WIDTH-2:0], din} << rx_shl);

    // Slot and bit counters; frame restarts on every recognised sync
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_cnt      <= 5'h00;
            rx_cnt      <= 5'h00;
            slot_idx    <= 5'h00;
            tx_active   <= 1'b0;
            fs_prev_bit <= 1'b0;
        end else begin
            if (rise) begin
                fs_prev_bit <= fsync;
            end
            if (slot_start) begin
                tx_active <= 1'b1;
                tx_cnt    <= (wl_bits == 5'h00) ? 5'h00 : 5'h01;
                if (tx_sync_ok) begin
                    slot_idx <= 5'h00;
                end else if (!ctrl[`SSD_CT_MOD] ||
                             slot_idx == ctrl[`SSD_CT_SLOTS_HI:`SSD_CT_SLOTS_LO]) begin
                    // Last slot reached without a new sync: wait for next frame
                    tx_active <= 1'b0;
                end else begin
                    slot_idx <= slot_idx + 5'h01;
                end
            end else if (rise && tx_active) begin
                tx_cnt <= (tx_cnt == wl_bits) ? 5'h00 : tx_cnt + 5'h01;
            end
            if (fall && tx_active) begin
                rx_cnt <= (rx_cnt == wl_bits) ? 5'h00 : rx_cnt + 5'h01;
            end
            if (slot_start && tx_sync_ok) begin
                rx_cnt <= 5'h00;
            end
        end
    end

    // Transmit shifter; held word reloads each slot so an underrun resends it
    ssd_shifter #(
        .WIDTH(WIDTH)
    ) u_tx_shift (
        .clk       (CLOCK),
        .rst       (RST),
        .load      (slot_start),
        .load_data (tx_hold),
        .shift     (rise && tx_active && !slot_start),
        .serial_in (1'b0),
        .lsb_first (lsb_first),
        .word_len  (word_len),
        .serial_out(tx_bit),
        .word      ()
    );

    // Receive shifter samples the data pin on falling bit clock
    // Cleared at every slot so a short word never carries bits of the one before
    ssd_shifter #(
        .WIDTH(WIDTH)
    ) u_rx_shift (
        .clk       (CLOCK),
        .rst       (RST),
        .load      (slot_start),
        .load_data ({WIDTH{1'b0}}),
        .shift     (fall && tx_active),
        .serial_in (din),
        .lsb_first (lsb_first),
        .word_len  (word_len),
        .serial_out(),
        .word      (rx_word)
    );

    // Output floats in skipped slots and while transmit is disabled
    assign SERIAL_OUT_PIN    = tx_bit;
    assign SERIAL_OUT_PIN_OE = tx_active && ctrl[`SSD_CT_TE] && !tx_skip_slot;

    // Control register write
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl <= `SSD_CTRL_RESET;
        end else if (WR && ADDR == `SSD_ADDR_CTRL) begin
            ctrl <= WDATA[18:0];
        end
    end

    // Transmit holding word and transmit-side flags
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_hold             <= {WIDTH{1'b0}};
            tx_holding_empty    <= 1'b1;
            tx_underrun_flag    <= 1'b0;
            tue_armed           <= 1'b0;
            tx_frame_start_flag <= 1'b0;
            tx_skip_pending     <= 1'b0;
            tx_skip_slot        <= 1'b0;
        end else begin
            // Low unused bits are never shifted out
            if (tx_wr) begin
                tx_hold <= WDATA[WIDTH-1:0];
            end
            if (tx_wr || skip_wr) begin
                tx_holding_empty <= 1'b0;
                tx_skip_pending  <= skip_wr;
            end
            if (status_rd && tx_underrun_flag) begin
                tue_armed <= 1'b1;
            end
            if ((tx_wr || skip_wr) && tue_armed) begin
                tx_underrun_flag <= 1'b0;
                tue_armed        <= 1'b0;
            end
            // Slot start: forwarding wins over the clearing write in the same cycle
            if (slot_start && (tx_active || tx_sync_ok)) begin
                tx_frame_start_flag <= tx_sync_ok;
                tx_skip_slot        <= tx_skip_pending;
                tx_skip_pending     <= 1'b0;
                tx_holding_empty    <= 1'b1;
                if (tx_holding_empty && !tx_wr && !skip_wr) begin
                    tx_underrun_flag <= 1'b1;
                    tue_armed        <= 1'b0;
                end
            end
        end
    end

    // Receive holding word and receive-side flags
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rx_hold             <= {WIDTH{1'b0}};
            rx_holding_full     <= 1'b0;
            rx_overrun_flag     <= 1'b0;
            roe_armed           <= 1'b0;
            rx_frame_start_flag <= 1'b0;
            rx_sync_seen        <= 1'b0;
            rx_first            <= 1'b0;
            rx_flag0_smp        <= 1'b0;
            rx_flag1_smp        <= 1'b0;
            input_flag_zero     <= 1'b0;
            input_flag_one      <= 1'b0;
        end else begin
            if (slot_start) begin
                rx_sync_seen <= tx_sync_ok && rx_sync_ok;
                rx_first     <= 1'b1;
            end
            // Aux pins caught on the first received bit of the word
            if (fall && rx_first) begin
                rx_flag0_smp <= a0_s[1];
                rx_flag1_smp <= a1_s[1];
                rx_first     <= 1'b0;
            end
            if (rx_rd) begin
                rx_holding_full <= 1'b0;
            end
            if (status_rd && rx_overrun_flag) begin
                roe_armed <= 1'b1;
            end
            if (rx_rd && roe_armed) begin
                rx_overrun_flag <= 1'b0;
                roe_armed       <= 1'b0;
            end
            // Word complete; transfer gated by receive enable, overrun if still full
            if (rx_done && ctrl[`SSD_CT_RE]) begin
                if (rx_holding_full && !rx_rd) begin
                    rx_overrun_flag <= 1'b1;
                    roe_armed       <= 1'b0;
                end else begin
                    rx_hold             <= rx_full;
                    rx_holding_full     <= 1'b1;
                    rx_frame_start_flag <= rx_sync_seen || !ctrl[`SSD_CT_MOD];
                    input_flag_zero     <= rx_flag0_smp;
                    input_flag_one      <= rx_flag1_smp;
                end
            end
        end
    end

    // Input flags gated by pin direction and synchronous mode
    assign status = {rx_holding_full, tx_holding_empty, rx_overrun_flag, tx_underrun_flag,
                     rx_frame_start_flag, tx_frame_start_flag,
                     input_flag_one && !ctrl[`SSD_CT_DIR1] && ctrl[`SSD_CT_SYN],
                     input_flag_zero && !ctrl[`SSD_CT_DIR0] && ctrl[`SSD_CT_SYN]};

    // Read data one cycle after the strobe; unmapped reads return zero
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RDATA <= 24'h000000;
        end else if (RD) begin
            case (ADDR)
                `SSD_ADDR_STATUS: RDATA <= {16'h0000, status};
                `SSD_ADDR_RXDATA: RDATA <= rx_hold;
                `SSD_ADDR_CTRL:   RDATA <= {5'h00, ctrl};
                `SSD_ADDR_VECTOR: RDATA <= {20'h00000, TX_IRQ_EXC, TX_IRQ, RX_IRQ_EXC, RX_IRQ};
                default:          RDATA <= 24'h000000;
            endcase
        end else begin
            RDATA <= 24'h000000;
        end
    end

    // Error flags only steer the vector choice
    assign TX_IRQ     = ctrl[`SSD_CT_TIE] && tx_holding_empty && !tx_underrun_flag;
    assign TX_IRQ_EXC = ctrl[`SSD_CT_TIE] && tx_holding_empty && tx_underrun_flag;
    assign RX_IRQ     = ctrl[`SSD_CT_RIE] && rx_holding_full && !rx_overrun_flag;
    assign RX_IRQ_EXC = ctrl[`SSD_CT_RIE] && rx_holding_full && rx_overrun_flag;
endmodule

// [hw/ssd_shifter.v]
// Bidirectional-order shift register with selectable word length
`include "ssd_consts.vh"

module ssd_shifter #(
    parameter WIDTH = 24
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Control
    input  wire             load,
    input  wire [WIDTH-1:0] load_data,
    input  wire             shift,
    input  wire             serial_in,
    input  wire             lsb_first,
    input  wire [1:0]       word_len,
    // Outputs
    output wire             serial_out,
    output reg  [WIDTH-1:0] word
);
    reg [WIDTH-1:0] next_word;
    reg [4:0]       top;

    // Top bit index of the active word, kept left-justified
    always @* begin
        case (word_len)
            2'h0:    top = 5'h07;
            2'h1:    top = 5'h0b;
            2'h2:    top = 5'h0f;
            default: top = 5'h17;
        endcase
    end

    // Left-justified word: output from the MSB, or from the bottom of the active field
    assign serial_out = lsb_first ? word[WIDTH-1-top] : word[WIDTH-1];

    // Shift path; LSB-first walks the active field toward the top
    always @* begin
        next_word = word;
        if (load) begin
            next_word = load_data;
        end else if (shift) begin
            if (lsb_first) begin
                next_word = {serial_in, word[WIDTH-1:1]};
            end else begin
                next_word = {word[WIDTH-2:0], serial_in};
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            word <= {WIDTH{1'b0}};
        end else begin
            word <= next_word;
        end
    end
endmodule

// [sim/ssd_codec.sv]
// Behavioural serial peer: one word per frame, link clock still between
module ssd_codec (
    // Link pins toward the port
    output logic bit_clk,
    output logic frame_sync,
    output logic serial_in,
    // Transmit pins watched from the port
    input  wire  serial_out,
    input  wire  serial_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] rx_word;
    logic        oe_seen;

    // Idle link
    initial begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        serial_in = 1'b0;
        rx_word = 24'h000000;
        oe_seen = 1'b0;
    end

    // Word-length frame; data moves on rise, both ends sample on fall
    task automatic frame(input logic [23:0] w, input int n, input bit lsb);
        int k;
        int idx;
        rx_word = 24'h000000;
        oe_seen = 1'b0;
        for (k = 0; k < n; k++) begin
            idx = lsb ? 24 - n + k : 23 - k;
            frame_sync = 1'b1;
            serial_in = w[idx];
            bit_clk = 1'b1;
            #160;
            bit_clk = 1'b0;
            rx_word[idx] = serial_out;
            oe_seen = oe_seen | serial_oe;
            #160;
        end
        frame_sync = 1'b0;
        // Released line flips so a stale bit cannot pass as data
        serial_in = ~serial_in;
    endtask
endmodule

// [sim/ssd_port_props.sv]
// Assertions on the register port and request pins of the serial port
`include "ssd_consts.vh"

module ssd_port_props (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [23:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic [23:0] RDATA,
    // Requests
    input  wire logic        TX_IRQ,
    input  wire logic        TX_IRQ_EXC,
    input  wire logic        RX_IRQ,
    input  wire logic        RX_IRQ_EXC
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // Named steps of register traffic and quiet request pins
    sequence s_read(a);
        RD && ADDR == a;
    endsequence
    sequence s_tx_fill;
        WR && (ADDR == `SSD_ADDR_TXDATA || ADDR == `SSD_ADDR_SKIP);
    endsequence
    sequence s_tx_quiet;
        !TX_IRQ && !TX_IRQ_EXC;
    endsequence
    sequence s_rx_quiet;
        !RX_IRQ && !RX_IRQ_EXC;
    endsequence

    // Read data path
    property p_status_upper;
        s_read(`SSD_ADDR_STATUS) |=> RDATA[23:8] == 16'h0000;
    endproperty
    a_status_upper: assert property (p_status_upper)
        else $error("status upper bits not zero");
    property p_unmapped;
        RD && ADDR > `SSD_ADDR_VECTOR |=> RDATA == 24'h000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_quiet;
        !RD |=> RDATA == 24'h000000;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data outside read cycle");

    // Vector choice is one of two, never both
    property p_tx_excl;
        !(TX_IRQ && TX_IRQ_EXC);
    endproperty
    a_tx_excl: assert property (p_tx_excl)
        else $error("both transmit vectors requested");
    property p_rx_excl;
        !(RX_IRQ && RX_IRQ_EXC);
    endproperty
    a_rx_excl: assert property (p_rx_excl)
        else $error("both receive vectors requested");

    // Filling or draining withdraws the request next cycle
    property p_tx_fill;
        s_tx_fill |=> s_tx_quiet;
    endproperty
    a_tx_fill: assert property (p_tx_fill)
        else $error("transmit request after fill");
    property p_rx_drain;
        s_read(`SSD_ADDR_RXDATA) |=> s_rx_quiet;
    endproperty
    a_rx_drain: assert property (p_rx_drain)
        else $error("receive request after drain");

    // Cleared enable bits mask the requests
    property p_tie_off;
        WR && ADDR == `SSD_ADDR_CTRL && !WDATA[`SSD_CT_TIE] |=> s_tx_quiet;
    endproperty
    a_tie_off: assert property (p_tie_off)
        else $error("transmit request while masked");
    property p_rie_off;
        WR && ADDR == `SSD_ADDR_CTRL && !WDATA[`SSD_CT_RIE] |=> s_rx_quiet;
    endproperty
    a_rie_off: assert property (p_rie_off)
        else $error("receive request while masked");
endmodule

bind ssd_port ssd_port_props i_props (
    .CLOCK      (CLOCK),
    .RST        (RST),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .RDATA      (RDATA),
    .TX_IRQ     (TX_IRQ),
    .TX_IRQ_EXC (TX_IRQ_EXC),
    .RX_IRQ     (RX_IRQ),
    .RX_IRQ_EXC (RX_IRQ_EXC)
);

// [sim/ssd_port_test.sv]
// Self-checking bench for the serial status and data path port
`include "ssd_consts.vh"

module ssd_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLOCK, RST, WR, RD, AUX_PIN_ZERO, AUX_PIN_ONE;
    logic [3:0]  ADDR;
    logic [23:0] WDATA, d;
    wire  [23:0] RDATA;
    wire         BIT_CLK, FRAME_SYNC, SERIAL_IN, SERIAL_OUT_PIN, SERIAL_OUT_PIN_OE;
    wire         TX_IRQ, TX_IRQ_EXC, RX_IRQ, RX_IRQ_EXC;
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;

    ssd_port i_dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .BIT_CLK(BIT_CLK), .FRAME_SYNC(FRAME_SYNC),
        .SERIAL_IN(SERIAL_IN), .AUX_PIN_ZERO(AUX_PIN_ZERO), .AUX_PIN_ONE(AUX_PIN_ONE),
        .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE),
        .TX_IRQ(TX_IRQ), .TX_IRQ_EXC(TX_IRQ_EXC), .RX_IRQ(RX_IRQ), .RX_IRQ_EXC(RX_IRQ_EXC));
    ssd_codec i_codec (.bit_clk(BIT_CLK), .frame_sync(FRAME_SYNC), .serial_in(SERIAL_IN),
        .serial_out(SERIAL_OUT_PIN), .serial_oe(SERIAL_OUT_PIN_OE));

    // 25 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t run did not finish", $time);
            wrap_up();
        end
    end

    // Register port: one-cycle strobes, read data in the following cycle
    task wr(input logic [3:0] a, input logic [23:0] v);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, output logic [23:0] v);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        v = RDATA;
    endtask

    // Comparisons
    task chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask

    // One frame from the peer, then time for the synchronisers to settle
    task run_frame(input logic [23:0] w, input int n, input bit lsb);
        i_codec.frame(w, n, lsb);
        repeat (10) @(posedge CLOCK);
        #1;
    endtask

    task t_reset;
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h000040, "status after reset");
        rd(4'hf, d);
        chk_word(d, 24'h000000, "unmapped read");
        wr(`SSD_ADDR_CTRL, 24'h000000);
        chk_bit(TX_IRQ, 1'b0, "masked transmit request");
        $display("test reset done");
    endtask

    // 24-bit MSB-first word each way, flags pins enabled
    task t_loop;
        @(posedge CLOCK);
        AUX_PIN_ONE <= 1'b1;
        wr(`SSD_ADDR_CTRL, 24'h0007a3);
        chk_bit(TX_IRQ, 1'b1, "transmit request when empty");
        wr(`SSD_ADDR_TXDATA, 24'ha5c3f1);
        chk_bit(TX_IRQ, 1'b0, "transmit request after fill");
        run_frame(24'h3c5a96, 24, 1'b0);
        chk_word(i_codec.rx_word, 24'ha5c3f1, "serial out word");
        chk_bit(i_codec.oe_seen, 1'b1, "output driven");
        chk_bit(RX_IRQ, 1'b1, "receive request");
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h0000ce, "status after frame");
        rd(`SSD_ADDR_RXDATA, d);
        chk_word(d, 24'h3c5a96, "received word");
        chk_bit(RX_IRQ, 1'b0, "receive request after read");
        $display("test loop done");
    endtask

    // 8-bit LSB-first word, low bits of the write ignored, flag pins outputs
    task t_short;
        @(posedge CLOCK);
        AUX_PIN_ZERO <= 1'b1;
        wr(`SSD_ADDR_CTRL, 24'h001fa4);
        wr(`SSD_ADDR_TXDATA, 24'hb4ffff);
        run_frame(24'h2d0000, 8, 1'b1);
        chk_word(i_codec.rx_word, 24'hb40000, "short word out");
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h0000cc, "flags read zero");
        rd(`SSD_ADDR_RXDATA, d);
        chk_word(d, 24'h2d0000, "short word in");
        $display("test short done");
    endtask

    // Two frames with no service: underrun and overrun, then clearing
    task t_errors;
        run_frame(24'h110000, 8, 1'b1);
        run_frame(24'h220000, 8, 1'b1);
        chk_word(i_codec.rx_word, 24'hb40000, "previous word resent");
        chk_bit(TX_IRQ_EXC, 1'b1, "transmit exception vector");
        chk_bit(RX_IRQ_EXC, 1'b1, "receive exception vector");
        wr(`SSD_ADDR_SKIP, 24'h000000);
        rd(`SSD_ADDR_RXDATA, d);
        chk_word(d, 24'h110000, "second word dropped");
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h00003c, "errors kept without arming");
        wr(`SSD_ADDR_SKIP, 24'h000000);
        rd(`SSD_ADDR_RXDATA, d);
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h00000c, "errors cleared");
        $display("test errors done");
    endtask

    // Skipped slot floats the output, then a reset in mid-run
    task t_skip;
        run_frame(24'h330000, 8, 1'b1);
        chk_bit(i_codec.oe_seen, 1'b0, "output floats in skipped slot");
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h0000cc, "status after skipped slot");
        @(posedge CLOCK);
        RST <= 1'b1;
        @(posedge CLOCK);
        RST <= 1'b0;
        rd(`SSD_ADDR_STATUS, d);
        chk_word(d, 24'h000040, "status after second reset");
        chk_bit(RX_IRQ, 1'b0, "receive request after reset");
        $display("test skip done");
    endtask

    task wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 4'h0;
        WDATA = 24'h000000;
        AUX_PIN_ZERO = 1'b0;
        AUX_PIN_ONE = 1'b0;
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        t_reset();
        t_loop();
        t_short();
        t_errors();
        t_skip();
        wrap_up();
    end
endmodule
